//--- bench/host_model.sv
`timescale 1ns/1ps
// ==========================================
// upstream master, bit-banged on 160 ns ticks
module host_model (
  output logic scl,
  output logic sda_rel,
  input wire logic sda_line
);
  // idle bus: both lines released to the pull-up
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // quarter bit of four ticks keeps scl near 390 kHz
  task automatic q;
    #640;
  endtask : q
  // odd offset keeps edges off the system clock grid
  task automatic start_c;
    #13;
    q();
    sda_rel = 1'b0;
    q();
    scl = 1'b0;
    q();
  endtask : start_c
  task automatic stop_c;
    sda_rel = 1'b0;
    q();
    scl = 1'b1;
    q();
    sda_rel = 1'b1;
    q();
  endtask : stop_c
  // data moves only while scl is low, else it reads as start or stop
  task automatic bit_io(input logic b, output logic s);
    sda_rel = b;
    q();
    scl = 1'b1;
    q();
    s = sda_line;
    q();
    scl = 1'b0;
    q();
  endtask : bit_io
  // msb first, ninth bit reads the acknowledge (low = taken)
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic nak);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tx[i], rx[i]);
    end
    bit_io(1'b1, nak);
  endtask : xfer
  // holding scl low is how a stuck bus is made
  task automatic hold_scl(input logic v);
    #7;
    scl = v;
  endtask : hold_scl
endmodule : host_model

//--- bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import mux_fault_pkg::*;
  localparam logic [6:0] DEV = 7'h2A; // arbitrary bus address
  localparam int unsigned LIM_L = 400;
  localparam int unsigned LIM_M = 200;
  localparam int unsigned LIM_S = 100;
  typedef struct {
    logic [3:0] f, bh, sel, ec;
    logic rq, ef, ea;
  } row_t;
  logic sys_clk = 1'b0, reset = 1'b1, enable = 1'b1, conn_require = 1'b0, connect_stb = 1'b0;
  logic [3:0] fault_n = 4'hF, bus_high = 4'hF, connect_sel = 4'h0, conn, levels;
  tosel_t timeout_select = TOSEL_OFF;
  logic scl, sda_rel, sda_o, sda_oe, alert_o, alert_oe, down_conn, failed, to_lat, to_rt, nak;
  logic [7:0] got;
  int err_total = 0;
  int checked = 0;
  // open-drain data wire with pull-up
  wire sda_line = sda_rel & ~(sda_oe & ~sda_o);
  row_t rows [4] = '{
    '{4'hF, 4'hF, 4'h3, 4'h3, 1'b0, 1'b0, 1'b0},
    '{4'hB, 4'hF, 4'h3, 4'h3, 1'b0, 1'b0, 1'b1},
    '{4'hF, 4'hB, 4'h5, 4'h1, 1'b0, 1'b1, 1'b1},
    '{4'hF, 4'hB, 4'h4, 4'h4, 1'b1, 1'b1, 1'b1}};
  tosel_t code [3] = '{TOSEL_LONG, TOSEL_MID, TOSEL_SHORT};
  int unsigned lim [3] = '{LIM_L, LIM_M, LIM_S};

  always #25 sys_clk = ~sys_clk;

  mux_fault_ctrl #(.DEV_ADDR(DEV), .TO_LONG(LIM_L), .TO_MID(LIM_M), .TO_SHORT(LIM_S)) dut_u (
    .SYS_CLK(sys_clk), .RESET(reset), .UP_SCL_CLK(scl), .UP_SCL_I(scl),
    .UP_SDA_I(sda_line), .UP_SDA_O(sda_o), .UP_SDA_OE(sda_oe), .ENABLE(enable),
    .CHANNEL_FAULT_INPUTS_N(fault_n), .DOWNSTREAM_BUS_HIGH(bus_high),
    .TIMEOUT_SELECT(timeout_select), .CONN_REQUIRE(conn_require),
    .CONNECT_STB(connect_stb), .CONNECT_SEL(connect_sel), .FAULT_ALERT_O(alert_o),
    .FAULT_ALERT_OE(alert_oe), .CHANNEL_CONNECTED(conn), .DOWN_CONNECTED(down_conn),
    .FAULT_LEVELS(levels), .FAILED_CONNECT(failed), .TIMEOUT_LATCHED(to_lat),
    .TIMEOUT_REALTIME(to_rt));
  host_model host_u (.scl(scl), .sda_rel(sda_rel), .sda_line(sda_line));

  // ==========================================
  // compare and report
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_bit
  task automatic cmp_vec(input string nm, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_vec
  task automatic close_out;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : close_out
  // ==========================================
  // stimulus helpers
  task automatic connect(input logic [3:0] sel, input logic rq);
    @(posedge sys_clk);
    connect_sel <= sel;
    conn_require <= rq;
    connect_stb <= 1'b1;
    @(posedge sys_clk);
    connect_stb <= 1'b0;
  endtask : connect
  task automatic host_write(input logic [7:0] ptr, input logic [7:0] dat);
    logic [7:0] rx;
    logic a0, a1, a2;
    host_u.start_c();
    host_u.xfer({DEV, 1'b0}, rx, a0);
    host_u.xfer(ptr, rx, a1);
    host_u.xfer(dat, rx, a2);
    host_u.stop_c();
    nak = a0 | a1 | a2;
  endtask : host_write
  // master releases the data byte and answers it with a nack
  task automatic host_ara;
    logic d;
    host_u.start_c();
    host_u.xfer({ARA_ADDR, 1'b1}, got, nak);
    host_u.xfer(8'hFF, got, d);
    host_u.stop_c();
  endtask : host_ara
  // bounded wait; running out ends the run at once
  task automatic wait_rt(input int n);
    int k;
    k = 0;
    while (to_rt !== 1'b1 && k < n) begin
      @(posedge sys_clk);
      k++;
    end
    if (k >= n) begin
      err_total++;
      $display("ERROR timeout_wait expected 1 seen 0");
      close_out();
    end
  endtask : wait_rt

  // ==========================================
  // main sequence
  initial begin
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (8) @(posedge sys_clk);
    cmp_vec("connected", 8'h00, {4'h0, conn});
    cmp_bit("alert", 1'b0, alert_oe);
    cmp_bit("alert_level", 1'b0, alert_o);
    $display("reset test done");
    // ordinary connect and fault cases
    for (int i = 0; i < 4; i++) begin
      @(posedge sys_clk);
      fault_n <= rows[i].f;
      bus_high <= rows[i].bh;
      // pin filters need five cycles before the request sees the levels
      repeat (8) @(posedge sys_clk);
      connect(rows[i].sel, rows[i].rq);
      repeat (10) @(posedge sys_clk);
      cmp_vec("connected", {4'h0, rows[i].ec}, {4'h0, conn});
      cmp_bit("down_connected", |rows[i].ec, down_conn);
      cmp_bit("failed", rows[i].ef, failed);
      cmp_bit("alert", rows[i].ea, alert_oe);
      cmp_vec("levels", {4'h0, rows[i].f}, {4'h0, levels});
      $display("row %0d done", i);
    end
    // status clear releases the alert and leaves the switches alone
    host_write(STATUS_IDX, 8'h00);
    repeat (10) @(posedge sys_clk);
    cmp_bit("write_nak", 1'b0, nak);
    cmp_bit("failed", 1'b0, failed);
    cmp_bit("alert", 1'b0, alert_oe);
    cmp_vec("connected", 8'h04, {4'h0, conn});
    $display("clear test done");
    // alert response: silent without alert, answers with it
    host_ara();
    cmp_bit("ara_nak", 1'b1, nak);
    @(posedge sys_clk);
    fault_n <= 4'hE;
    repeat (10) @(posedge sys_clk);
    host_ara();
    cmp_bit("ara_nak", 1'b0, nak);
    cmp_vec("ara_byte", {DEV, 1'b0}, got);
    cmp_bit("sda_level", 1'b0, sda_o);
    @(posedge sys_clk);
    fault_n <= 4'hF;
    $display("response test done");
    // stuck-low timer for every nonzero select code
    for (int i = 0; i < 3; i++) begin
      connect(4'hF, 1'b1);
      timeout_select <= code[i];
      host_u.hold_scl(1'b0);
      repeat (lim[i] - 2) @(posedge sys_clk);
      cmp_bit("timeout_realtime", 1'b0, to_rt);
      wait_rt(24);
      cmp_bit("timeout_latched", 1'b1, to_lat);
      cmp_vec("connected", 8'h00, {4'h0, conn});
      repeat (2) @(posedge sys_clk);
      cmp_bit("alert", 1'b1, alert_oe);
      host_u.hold_scl(1'b1);
      repeat (10) @(posedge sys_clk);
      cmp_bit("timeout_realtime", 1'b0, to_rt);
      cmp_bit("timeout_latched", 1'b1, to_lat);
      // a frame of zero bytes outlasts the short limits, so timer off first
      timeout_select <= TOSEL_OFF;
      host_write(STATUS_IDX, 8'h00);
      repeat (10) @(posedge sys_clk);
      cmp_bit("timeout_latched", 1'b0, to_lat);
      cmp_bit("alert", 1'b0, alert_oe);
      $display("timeout code %0d done", i + 1);
    end
    // select 00 never times out, even well past the longest limit
    timeout_select <= TOSEL_OFF;
    host_u.hold_scl(1'b0);
    repeat (LIM_L + 200) @(posedge sys_clk);
    cmp_bit("timeout_realtime", 1'b0, to_rt);
    cmp_bit("alert", 1'b0, alert_oe);
    host_u.hold_scl(1'b1);
    $display("timeout off done");
    // enable low drops state and ignores the bus
    connect(4'hF, 1'b0);
    @(posedge sys_clk);
    bus_high <= 4'hF;
    enable <= 1'b0;
    repeat (10) @(posedge sys_clk);
    cmp_vec("connected", 8'h00, {4'h0, conn});
    cmp_bit("failed", 1'b0, failed);
    host_write(STATUS_IDX, 8'h00);
    cmp_bit("write_nak", 1'b1, nak);
    @(posedge sys_clk);
    enable <= 1'b1;
    repeat (10) @(posedge sys_clk);
    host_write(STATUS_IDX, 8'h00);
    cmp_bit("write_nak", 1'b0, nak);
    $display("enable test done");
    // one-sample spike on a fault input never reaches the alert
    @(posedge sys_clk);
    fault_n <= 4'hE;
    @(posedge sys_clk);
    fault_n <= 4'hF;
    repeat (10) @(posedge sys_clk);
    cmp_vec("levels", 8'h0F, {4'h0, levels});
    cmp_bit("alert", 1'b0, alert_oe);
    $display("spike test done");
    // reset in mid-run drops state; pins reappear only after the filters
    fault_n <= 4'hE;
    connect(4'h3, 1'b1);
    repeat (10) @(posedge sys_clk);
    cmp_vec("connected", 8'h03, {4'h0, conn});
    reset <= 1'b1;
    repeat (8) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (2) @(posedge sys_clk);
    cmp_vec("connected", 8'h00, {4'h0, conn});
    cmp_bit("alert", 1'b0, alert_oe);
    repeat (10) @(posedge sys_clk);
    cmp_bit("alert", 1'b1, alert_oe);
    fault_n <= 4'hF;
    $display("mid-run reset test done");
    close_out();
  end
endmodule : tb_top

//--- hdl/mux_fault_ctrl.sv
`timescale 1ns/1ps
module mux_fault_ctrl #(
  parameter logic [6:0] DEV_ADDR = 7'h2A, // arbitrary default slave address
  parameter int unsigned TO_LONG = mux_fault_pkg::TO_LONG_CYC,
  parameter int unsigned TO_MID = mux_fault_pkg::TO_MID_CYC,
  parameter int unsigned TO_SHORT = mux_fault_pkg::TO_SHORT_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic UP_SCL_CLK,
  input wire logic UP_SCL_I,
  input wire logic UP_SDA_I,
  output logic UP_SDA_O,
  output logic UP_SDA_OE,
  input wire logic ENABLE,
  input wire logic [3:0] CHANNEL_FAULT_INPUTS_N,
  input wire logic [3:0] DOWNSTREAM_BUS_HIGH,
  input wire mux_fault_pkg::tosel_t TIMEOUT_SELECT,
  input wire logic CONN_REQUIRE,
  input wire logic CONNECT_STB,
  input wire logic [3:0] CONNECT_SEL,
  output logic FAULT_ALERT_O,
  output logic FAULT_ALERT_OE,
  output logic [3:0] CHANNEL_CONNECTED,
  output logic DOWN_CONNECTED,
  output logic [3:0] FAULT_LEVELS,
  output logic FAILED_CONNECT,
  output logic TIMEOUT_LATCHED,
  output logic TIMEOUT_REALTIME
);
  import mux_fault_pkg::*;

  // ==========================================================================
  // pin conditioning in the system domain
  logic [10:0] filt;
  logic en_f, scl_f, sda_f;
  logic [3:0] fault_f, bus_high_f;

  pin_filter #(
    .W(11),
    .FILT_CYC(4'(SPIKE_CYC)),
    .RST_VAL(11'h7FF)
  ) u_filt (
    .clk(SYS_CLK),
    .rst(RESET),
    .d({ENABLE, DOWNSTREAM_BUS_HIGH, CHANNEL_FAULT_INPUTS_N, UP_SCL_I, UP_SDA_I}),
    .q(filt)
  );

  assign sda_f = filt[0];
  assign scl_f = filt[1];
  assign fault_f = filt[5:2];
  assign bus_high_f = filt[9:6];
  assign en_f = filt[10];

  // ==========================================================================
  // start and stop detection, frame reset for the link side
  logic sda_prev_q, frame_rst_q, restart_q;
  logic start, stop;

  assign start = scl_f & sda_prev_q & ~sda_f;
  assign stop = scl_f & ~sda_prev_q & sda_f;

  // link logic is held reset between frames since its clock may stand still
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sda_prev_q <= 1'b1;
      restart_q <= 1'b0;
      frame_rst_q <= 1'b1;
    end else begin
      sda_prev_q <= sda_f;
      restart_q <= start & ~frame_rst_q;
      if (!en_f || stop) begin
        frame_rst_q <= 1'b1;
      end else if (start) begin
        frame_rst_q <= ~frame_rst_q;
      end else if (restart_q) begin
        frame_rst_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // clear event from the link, toggle crossing
  logic clr_tgl_q;
  logic c1_q, c2_q, c3_q;
  logic clr_pulse;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      c1_q <= 1'b0;
      c2_q <= 1'b0;
      c3_q <= 1'b0;
    end else begin
      c1_q <= clr_tgl_q;
      c2_q <= c1_q;
      c3_q <= c2_q;
    end
  end
  assign clr_pulse = c2_q ^ c3_q;

  // ==========================================================================
  // stuck-low timer
  logic [TIMER_W-1:0] tmr_q, lim;
  logic bus_low, to_hit, to_rt_q, to_lat_q;

  always_comb begin
    case (TIMEOUT_SELECT)
      TOSEL_LONG: lim = TIMER_W'(TO_LONG);
      TOSEL_MID: lim = TIMER_W'(TO_MID);
      TOSEL_SHORT: lim = TIMER_W'(TO_SHORT);
      default: lim = '0;
    endcase
  end

  assign bus_low = ~scl_f | ~sda_f;
  assign to_hit = bus_low && (TIMEOUT_SELECT != TOSEL_OFF) && (tmr_q >= lim);

  // a shorter select mid-count expires at once, never wraps
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      tmr_q <= '0;
    end else if (!bus_low || !en_f || TIMEOUT_SELECT == TOSEL_OFF) begin
      tmr_q <= '0;
    end else if (tmr_q < lim) begin
      tmr_q <= tmr_q + TIMER_W'(1);
    end
  end

  // real-time flag follows the bus, latched flag waits for a status write
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      to_rt_q <= 1'b0;
      to_lat_q <= 1'b0;
    end else if (!en_f) begin
      to_rt_q <= 1'b0;
      to_lat_q <= 1'b0;
    end else begin
      to_rt_q <= to_hit;
      if (to_hit) begin
        to_lat_q <= 1'b1;
      end else if (clr_pulse) begin
        to_lat_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // channel connection and refused attempts
  logic [3:0] conn_q;
  logic failed_q, dc_q, refused;

  assign refused = CONNECT_STB & ~CONN_REQUIRE & (|(CONNECT_SEL & ~conn_q & ~bus_high_f));

  // a request replaces the channel set; low idle channels stay open unless CONN_REQUIRE is set
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      conn_q <= 4'h0;
      dc_q <= 1'b0;
    end else begin
      dc_q <= |conn_q;
      if (!en_f || to_hit) begin
        conn_q <= 4'h0;
      end else if (CONNECT_STB) begin
        conn_q <= CONNECT_SEL & (CONN_REQUIRE ? 4'hF : (bus_high_f | conn_q));
      end
    end
  end

  // set wins over a clear arriving in the same cycle
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      failed_q <= 1'b0;
    end else if (!en_f) begin
      failed_q <= 1'b0;
    end else if (refused) begin
      failed_q <= 1'b1;
    end else if (clr_pulse) begin
      failed_q <= 1'b0;
    end
  end

  // ==========================================================================
  // alert merge
  logic alert_q, od_low_q;

  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      alert_q <= 1'b0;
      od_low_q <= 1'b0;
    end else begin
      od_low_q <= 1'b0;
      alert_q <= (~&fault_f) | to_rt_q | to_lat_q | failed_q;
    end
  end

  assign FAULT_ALERT_OE = alert_q;
  assign FAULT_ALERT_O = od_low_q;
  assign UP_SDA_O = od_low_q;
  assign CHANNEL_CONNECTED = conn_q;
  assign DOWN_CONNECTED = dc_q;
  assign FAULT_LEVELS = fault_f;
  assign FAILED_CONNECT = failed_q;
  assign TIMEOUT_LATCHED = to_lat_q;
  assign TIMEOUT_REALTIME = to_rt_q;

  // ==========================================================================
  // link domain: byte engine on the upstream clock
  logic al1_q, al2_q, en1_q, en2_q;
  logic [3:0] bit_q;
  logic [2:0] byte_q;
  logic [7:0] sh_q, ptr_q, rx, ara_tx;
  link_mode_t mode_q;
  logic sda_oe_q;

  assign rx = {sh_q[6:0], UP_SDA_I};
  assign ara_tx = {DEV_ADDR, 1'b0};

  // levels into the link domain; a frame has several edges before they are used
  always_ff @(posedge UP_SCL_CLK or posedge RESET) begin
    if (RESET) begin
      al1_q <= 1'b0;
      al2_q <= 1'b0;
      en1_q <= 1'b0;
      en2_q <= 1'b0;
    end else begin
      al1_q <= alert_q;
      al2_q <= al1_q;
      en1_q <= en_f;
      en2_q <= en1_q;
    end
  end

  // bit and byte counting, address decode; 20 MHz sampling covers 400 kHz
  always_ff @(posedge UP_SCL_CLK or posedge frame_rst_q) begin
    if (frame_rst_q) begin
      bit_q <= 4'h0;
      byte_q <= 3'h0;
      sh_q <= 8'h00;
      ptr_q <= 8'h00;
      mode_q <= L_IDLE;
    end else begin
      sh_q <= rx;
      bit_q <= (bit_q == BIT_ACK) ? 4'h0 : bit_q + 4'h1;
      if (bit_q == BIT_ACK && byte_q != BYTE_MAX) begin
        byte_q <= byte_q + 3'h1;
      end
      if (bit_q == BIT_LAST && byte_q == 3'h0) begin
        if (!en2_q) begin
          mode_q <= L_IGNORE;
        end else if (rx[7:1] == DEV_ADDR && !rx[0]) begin
          mode_q <= L_WRITE;
        end else if (rx[7:1] == ARA_ADDR && rx[0] && al2_q) begin
          mode_q <= L_ARA;
        end else begin
          mode_q <= L_IGNORE;
        end
      end
      if (bit_q == BIT_LAST && byte_q == 3'h1 && mode_q == L_WRITE) begin
        ptr_q <= rx;
      end
    end
  end

  // data byte written at status index zero flips the clear toggle
  always_ff @(posedge UP_SCL_CLK or posedge RESET) begin
    if (RESET) begin
      clr_tgl_q <= 1'b0;
    end else if (!frame_rst_q && bit_q == BIT_LAST && byte_q >= 3'h2 &&
                 mode_q == L_WRITE && ptr_q == STATUS_IDX) begin
      clr_tgl_q <= ~clr_tgl_q;
    end
  end

  // data changes on the falling edge: acknowledge, then own address for the alert response
  always_ff @(negedge UP_SCL_CLK or posedge frame_rst_q) begin
    if (frame_rst_q) begin
      sda_oe_q <= 1'b0;
    end else begin
      sda_oe_q <= (bit_q == BIT_ACK && (mode_q == L_WRITE ||
                   (mode_q == L_ARA && byte_q == 3'h0))) ||
                  (mode_q == L_ARA && byte_q == 3'h1 && bit_q != BIT_ACK &&
                   !ara_tx[3'h7 - bit_q[2:0]]);
    end
  end
  assign UP_SDA_OE = sda_oe_q;

  // ==========================================================================
  // checks
  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (RESET);

  sequence s_quiet;
    (&fault_f) && !to_rt_q && !to_lat_q && !failed_q;
  endsequence

  a_fault_in_alert: assert property (
    !(&fault_f) |=> FAULT_ALERT_OE)
    else $error("channel fault did not raise the alert");
  a_stuck_alert: assert property (
    to_hit && en_f |=> ##1 FAULT_ALERT_OE)
    else $error("stuck bus did not raise the alert");
  a_refuse_alert: assert property (
    refused && en_f |=> FAILED_CONNECT ##1 FAULT_ALERT_OE)
    else $error("refused connect did not raise the alert");
  // a refused channel must stay open while the flag records the attempt
  a_refuse_flag: assert property (
    refused && en_f |=>
      FAILED_CONNECT && (CHANNEL_CONNECTED & ~$past(bus_high_f) & ~$past(conn_q)) == 4'h0)
    else $error("refused connect not recorded");
  a_timeout_expire: assert property (
    $rose(TIMEOUT_REALTIME) |-> $past(TIMEOUT_SELECT) != TOSEL_OFF && $past(tmr_q) >= $past(lim))
    else $error("timeout fired before its selected count");
  a_timeout_off: assert property (
    (TIMEOUT_SELECT == TOSEL_OFF) [*2] |=> !TIMEOUT_REALTIME && tmr_q == '0)
    else $error("timeout ran while disabled");
  a_enable_clear: assert property (
    !en_f |=> CHANNEL_CONNECTED == 4'h0 && !TIMEOUT_LATCHED && !FAILED_CONNECT)
    else $error("enable low did not force defaults");
  a_clear_latch: assert property (
    clr_pulse && !to_hit && !refused |=> !TIMEOUT_LATCHED && !FAILED_CONNECT)
    else $error("status write did not clear latched faults");
  a_timeout_disc: assert property (
    to_hit && en_f |=> CHANNEL_CONNECTED == 4'h0 && TIMEOUT_LATCHED && TIMEOUT_REALTIME)
    else $error("timeout did not disconnect and flag");
  a_alert_release: assert property (
    s_quiet |=> !FAULT_ALERT_OE)
    else $error("alert held with no cause");

endmodule : mux_fault_ctrl

//--- hdl/mux_fault_pkg.sv
package mux_fault_pkg;

  // ==========================================================================
  // clock and timing
  localparam int unsigned SYS_PERIOD_NS = 50;
  localparam int unsigned SYS_CLK_KHZ = 20000;
  localparam int unsigned SCL_MAX_KHZ = 400;
  localparam int unsigned SPIKE_NS = 50;
  // least time, so rounded up to whole cycles
  localparam int unsigned SPIKE_CYC = (SPIKE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
  // timeout figures in microseconds, converted at the system clock rate
  localparam int unsigned TO_LONG_US = 30000;
  localparam int unsigned TO_MID_US = 15000;
  localparam int unsigned TO_SHORT_US = 7500;
  localparam int unsigned TO_LONG_CYC = TO_LONG_US * (SYS_CLK_KHZ / 1000);
  localparam int unsigned TO_MID_CYC = TO_MID_US * (SYS_CLK_KHZ / 1000);
  localparam int unsigned TO_SHORT_CYC = TO_SHORT_US * (SYS_CLK_KHZ / 1000);
  localparam int unsigned TIMER_W = 20;

  // ==========================================================================
  // timeout select codes
  typedef logic [1:0] tosel_t;
  localparam tosel_t TOSEL_OFF = 2'h0;
  localparam tosel_t TOSEL_LONG = 2'h1;
  localparam tosel_t TOSEL_MID = 2'h2;
  localparam tosel_t TOSEL_SHORT = 2'h3;

  // ==========================================================================
  // two-wire framing
  localparam logic [6:0] ARA_ADDR = 7'h0C;
  localparam logic [7:0] STATUS_IDX = 8'h00;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK = 4'h8;
  localparam logic [2:0] BYTE_MAX = 3'h7;
  localparam int unsigned NCH = 4;

  typedef enum logic [3:0] {
    L_IDLE = 4'h1,
    L_WRITE = 4'h2,
    L_ARA = 4'h4,
    L_IGNORE = 4'h8
  } link_mode_t;

endpackage : mux_fault_pkg

//--- hdl/pin_filter.sv
`timescale 1ns/1ps
// ============================================================================
// three-flop synchroniser plus spike filter, one lane per bit
module pin_filter #(
  parameter int unsigned W = 1,
  parameter logic [3:0] FILT_CYC = 4'h1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_lane
      logic s1_q, s2_q, s3_q;
      logic [3:0] cnt_q;
      // first stage feeds only the second
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          s1_q <= RST_VAL[i];
          s2_q <= RST_VAL[i];
          s3_q <= RST_VAL[i];
        end else begin
          s1_q <= d[i];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // level moves only after stages 2 and 3 agree long enough
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          cnt_q <= 4'h0;
          q[i] <= RST_VAL[i];
        end else if (s2_q != s3_q) begin
          cnt_q <= 4'h0;
        end else if (cnt_q < FILT_CYC) begin
          cnt_q <= cnt_q + 4'h1;
        end else begin
          q[i] <= s3_q;
        end
      end
    end
  endgenerate

endmodule : pin_filter
